// >>> src/iwg_pkg.sv
// Register map, field layout and timing constants of the SCL waveform block
`default_nettype none

package iwg_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic [7:0] iwg_addr_t;
	typedef logic [31:0] iwg_word_t;
	typedef logic [7:0] iwg_div_t;
	typedef logic [2:0] iwg_exp_t;
	typedef logic [5:0] iwg_hold_t;
	typedef logic [15:0] iwg_len_t;
	typedef logic [6:0] iwg_hcnt_t;
	typedef logic [23:0] iwg_src_t;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam iwg_addr_t OFF_CTRL = 8'h00;
	localparam iwg_addr_t OFF_WAVE_CFG = 8'h10;
	localparam iwg_addr_t OFF_STATUS = 8'h20;
	localparam iwg_addr_t OFF_WP_MODE = 8'hE4;
	localparam iwg_addr_t OFF_WP_STATUS = 8'hE8;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int WAVE_HOLD_LSB = 24;
	localparam int WAVE_EXP_LSB = 16;
	localparam int WAVE_HIGH_LSB = 8;
	localparam int WAVE_LOW_LSB = 0;
	localparam iwg_word_t WAVE_MASK = 32'h3F07_FFFF;
	localparam iwg_word_t WAVE_RESET = 32'h0000_0000;
	localparam int WPS_SRC_LSB = 8;
	localparam int WPS_FLAG_BIT = 0;
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CTRL_HS_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int WPM_EN_BIT = 0;
	localparam logic WPM_RESET = 1'b0;
	localparam int STAT_SCL_BIT = 0;
	localparam int STAT_SDA_BIT = 1;
	localparam int STAT_DRV_BIT = 2;

	// ------------------------------------------------------------
	// Timing, in peripheral clock periods
	// ------------------------------------------------------------
	localparam iwg_len_t PHASE_EXTRA = 16'h0003;
	localparam iwg_hcnt_t HOLD_EXTRA = 7'h03;

	// Length of one SCL phase: divider scaled by 2**exp, plus fixed overhead
	function automatic iwg_len_t iwg_phase_len(input iwg_div_t div, input iwg_exp_t exp);
		iwg_len_t scaled;
		scaled = {8'h00, div} << exp;
		return scaled + PHASE_EXTRA;
	endfunction : iwg_phase_len

endpackage : iwg_pkg

`default_nettype wire

// >>> src/iwg_scl_timer.sv
// SCL phase timer and SDA hold timer
`default_nettype none

module iwg_scl_timer (
	input wire logic mclk,
	input wire logic srst,
	input wire logic run,
	input wire logic hs_mode,
	input wire iwg_pkg::iwg_div_t high_div,
	input wire iwg_pkg::iwg_div_t low_div,
	input wire iwg_pkg::iwg_exp_t exp_cfg,
	input wire iwg_pkg::iwg_hold_t hold_cfg,
	output logic scl_level,
	output logic scl_drive_low,
	output logic data_strobe
);
	import iwg_pkg::*;

	iwg_len_t cnt_reg;
	iwg_len_t phase_len_reg;
	iwg_hcnt_t hold_cnt_reg;
	iwg_len_t age_reg;
	logic [7:0] since_fall_reg;
	iwg_hcnt_t hold_lat_reg;

	// ------------------------------------------------------------
	// Phase decode
	// ------------------------------------------------------------
	wire logic toggle_now = run && (cnt_reg == '0);
	wire logic fall_now = toggle_now && scl_level;
	wire iwg_len_t hi_len = iwg_phase_len(high_div, exp_cfg);
	wire iwg_len_t lo_len = iwg_phase_len(low_div, exp_cfg);
	// Settings are sampled only at a phase boundary
	wire iwg_len_t new_len = fall_now ? lo_len : hi_len;
	wire iwg_hcnt_t hold_len = {1'b0, hold_cfg} + HOLD_EXTRA;

	assign data_strobe = (hs_mode && fall_now) || (hold_cnt_reg == 7'h01);

	// ------------------------------------------------------------
	// SCL phase counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_level <= 1'b1;
			scl_drive_low <= 1'b0;
			cnt_reg <= '0;
			phase_len_reg <= '0;
		end else if (!run) begin
			scl_level <= 1'b1;
			scl_drive_low <= 1'b0;
			cnt_reg <= hi_len - 16'h0001;
			phase_len_reg <= hi_len;
		end else if (toggle_now) begin
			scl_level <= !scl_level;
			scl_drive_low <= scl_level;
			cnt_reg <= new_len - 16'h0001;
			phase_len_reg <= new_len;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	// Hold count restarts on every falling edge; HS mode needs none
	always_ff @(posedge mclk) begin
		if (srst || !run) begin
			hold_cnt_reg <= '0;
		end else if (fall_now) begin
			hold_cnt_reg <= hs_mode ? '0 : hold_len;
		end else if (hold_cnt_reg != '0) begin
			hold_cnt_reg <= hold_cnt_reg - 7'h01;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst || !run || toggle_now) begin
			age_reg <= '0;
		end else begin
			age_reg <= age_reg + 16'h0001;
		end
		if (srst || fall_now) begin
			since_fall_reg <= '0;
			hold_lat_reg <= {1'b0, hold_cfg};
		end else if (since_fall_reg != 8'hFF) begin
			since_fall_reg <= since_fall_reg + 8'h01;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	AST_HIGH_LEN: assert property (run && toggle_now && scl_level |-> age_reg == phase_len_reg - 16'h0001)
		else $error("SCL high phase length wrong");
	AST_LOW_LEN: assert property (run && toggle_now && !scl_level |-> age_reg == phase_len_reg - 16'h0001)
		else $error("SCL low phase length wrong");
	AST_HIGH_FORMULA: assert property ($past(run) && $rose(scl_level)
		|-> phase_len_reg == iwg_phase_len($past(high_div), $past(exp_cfg)))
		else $error("High phase not scaled by prescaler");
	AST_LOW_FORMULA: assert property ($past(run) && $fell(scl_level)
		|-> phase_len_reg == iwg_phase_len($past(low_div), $past(exp_cfg)))
		else $error("Low phase not scaled by prescaler");
	AST_PHASE_KEPT: assert property (run && !toggle_now ##1 run |-> $stable(phase_len_reg))
		else $error("Phase length changed mid phase");
	AST_HS_EDGE: assert property ($past(run) && $fell(scl_level) && $past(hs_mode) |-> $past(data_strobe))
		else $error("HS data not moved on SCL fall");
	AST_HOLD_TIME: assert property (data_strobe && !fall_now
		|-> since_fall_reg == 8'(hold_lat_reg + 7'h02))
		else $error("SDA hold time wrong");
	CVR_HOLD: cover property (data_strobe && !fall_now && hold_lat_reg > 7'h02);

endmodule : iwg_scl_timer

`default_nettype wire

// >>> src/iwg_wave_gen.sv
// Top of the SCL waveform generator with its register slave
//
// Local design decision: the address-and-strobe port.
`default_nettype none

module iwg_wave_gen (
	input wire logic mclk,
	input wire logic srst,
	input wire iwg_pkg::iwg_addr_t reg_addr,
	input wire iwg_pkg::iwg_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output iwg_pkg::iwg_word_t reg_rdata,
	input wire logic tx_bit,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe
);
	import iwg_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [1:0] ctrl_reg;
	logic write_protect_enable_reg;
	iwg_word_t clock_waveform_config_reg;
	logic violation_flag_reg;
	iwg_src_t violation_source_offset_reg;
	iwg_word_t rdata_reg;
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_out_reg;
	logic sda_oe_reg;
	iwg_word_t rd_mux;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire logic hit_ctrl = (reg_addr == OFF_CTRL);
	wire logic hit_wave = (reg_addr == OFF_WAVE_CFG);
	wire logic hit_status = (reg_addr == OFF_STATUS);
	wire logic hit_wp_mode = (reg_addr == OFF_WP_MODE);
	wire logic hit_wp_status = (reg_addr == OFF_WP_STATUS);

	wire logic wave_wr = reg_wr && hit_wave;
	wire logic violation = wave_wr && write_protect_enable_reg;
	wire logic wave_take = wave_wr && !write_protect_enable_reg;
	wire logic wp_status_rd = reg_rd && hit_wp_status;

	wire logic master_mode = ctrl_reg[CTRL_MASTER_BIT];
	wire logic hs_mode = ctrl_reg[CTRL_HS_BIT];

	// ------------------------------------------------------------
	// Waveform fields
	// ------------------------------------------------------------
	wire iwg_hold_t hold_cfg = clock_waveform_config_reg[WAVE_HOLD_LSB +: 6];
	wire iwg_exp_t exp_cfg = clock_waveform_config_reg[WAVE_EXP_LSB +: 3];
	wire iwg_div_t high_div = clock_waveform_config_reg[WAVE_HIGH_LSB +: 8];
	wire iwg_div_t low_div = clock_waveform_config_reg[WAVE_LOW_LSB +: 8];

	wire logic data_strobe;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_reg <= CTRL_RESET;
			write_protect_enable_reg <= WPM_RESET;
		end else if (reg_wr && hit_ctrl) begin
			ctrl_reg <= {reg_wdata[CTRL_HS_BIT], reg_wdata[CTRL_MASTER_BIT]};
		end else if (reg_wr && hit_wp_mode) begin
			write_protect_enable_reg <= reg_wdata[WPM_EN_BIT];
		end
	end

	// Refused writes leave the settings untouched
	always_ff @(posedge mclk) begin
		if (srst) begin
			clock_waveform_config_reg <= WAVE_RESET;
		end else if (wave_take) begin
			clock_waveform_config_reg <= reg_wdata & WAVE_MASK;
		end
	end

	// ------------------------------------------------------------
	// Write protection violation
	// ------------------------------------------------------------
	// A violation in the same cycle as the clearing read wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			violation_flag_reg <= 1'b0;
		end else if (violation) begin
			violation_flag_reg <= 1'b1;
		end else if (wp_status_rd) begin
			violation_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			violation_source_offset_reg <= '0;
		end else if (violation) begin
			violation_source_offset_reg <= {16'h0000, reg_addr};
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = '0;
		if (hit_ctrl) begin
			rd_mux[CTRL_MASTER_BIT] = master_mode;
			rd_mux[CTRL_HS_BIT] = hs_mode;
		end else if (hit_wave) begin
			rd_mux = clock_waveform_config_reg;
		end else if (hit_status) begin
			rd_mux[STAT_SCL_BIT] = scl_sync_reg;
			rd_mux[STAT_SDA_BIT] = sda_sync_reg;
			rd_mux[STAT_DRV_BIT] = serial_clock_pin_out;
		end else if (hit_wp_mode) begin
			rd_mux[WPM_EN_BIT] = write_protect_enable_reg;
		end else if (hit_wp_status) begin
			rd_mux[WPS_SRC_LSB +: 24] = violation_source_offset_reg;
			rd_mux[WPS_FLAG_BIT] = violation_flag_reg;
		end
	end

	// Data stand for exactly one cycle; unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : '0;
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
		end else begin
			scl_meta_reg <= serial_clock_pin_in;
			scl_sync_reg <= scl_meta_reg;
			sda_meta_reg <= serial_data_pin_in;
			sda_sync_reg <= sda_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// SCL generation
	// ------------------------------------------------------------
	iwg_scl_timer u_timer (
		.mclk(mclk),
		.srst(srst),
		.run(master_mode),
		.hs_mode(hs_mode),
		.high_div(high_div),
		.low_div(low_div),
		.exp_cfg(exp_cfg),
		.hold_cfg(hold_cfg),
		.scl_level(serial_clock_pin_out),
		.scl_drive_low(serial_clock_pin_oe),
		.data_strobe(data_strobe)
	);

	// ------------------------------------------------------------
	// SDA drive
	// ------------------------------------------------------------
	// Open drain: only a zero is driven, a one releases the line
	always_ff @(posedge mclk) begin
		if (srst || !master_mode) begin
			sda_out_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
		end else if (data_strobe) begin
			sda_out_reg <= tx_bit;
			sda_oe_reg <= !tx_bit;
		end
	end

	assign serial_data_pin_out = sda_out_reg;
	assign serial_data_pin_oe = sda_oe_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	AST_WAVE_LOCKED: assert property (violation |=> $stable(clock_waveform_config_reg))
		else $error("Protected waveform register was written");
	AST_WAVE_TAKEN: assert property (wave_take
		|=> clock_waveform_config_reg == ($past(reg_wdata) & WAVE_MASK))
		else $error("Unprotected waveform write lost");
	AST_SLAVE_QUIET: assert property (!master_mode |=> !serial_clock_pin_oe && !serial_data_pin_oe)
		else $error("Bus driven outside master mode");
	AST_DATA_MOVE: assert property (master_mode && data_strobe
		|=> serial_data_pin_out == $past(tx_bit))
		else $error("SDA not updated at end of hold");
	AST_DATA_STILL: assert property (master_mode && !data_strobe ##1 master_mode
		|-> $stable(serial_data_pin_out))
		else $error("SDA moved outside its slot");
	AST_VIOL_SRC: assert property (violation
		|=> violation_flag_reg && violation_source_offset_reg == {16'h0000, $past(reg_addr)})
		else $error("Violation source not recorded");
	AST_VIOL_STICKY: assert property (violation_flag_reg && !wp_status_rd |=> violation_flag_reg)
		else $error("Violation flag dropped without read");
	AST_VIOL_CLEAR: assert property (wp_status_rd && !violation
		|=> !violation_flag_reg ##1 ($past(reg_rd) || reg_rdata == '0))
		else $error("Violation flag not cleared by read");
	AST_RD_FLAG: assert property (wp_status_rd
		|=> reg_rdata[WPS_FLAG_BIT] == $past(violation_flag_reg))
		else $error("Status read shows wrong flag");

	CVR_VIOLATION: cover property (violation ##[1:20] wp_status_rd);
	CVR_SET_WINS: cover property (violation && wp_status_rd);
	CVR_HS_DATA: cover property (master_mode && hs_mode && data_strobe);

endmodule : iwg_wave_gen

`default_nettype wire

// >>> tb/iwg_slave_model.sv
// Far-side stand-in: bus pull-ups and a slave that may hold SDA low
`default_nettype none

module iwg_slave_model (
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic ack_low,
	output logic scl_wire,
	output logic sda_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released lines float to the pull-up level; this slave never stretches SCL
	assign scl_wire = scl_oe ? 1'b0 : 1'b1;
	assign sda_wire = (sda_oe || ack_low) ? 1'b0 : 1'b1;

endmodule : iwg_slave_model

`default_nettype wire

// >>> tb/iwg_wave_gen_tb.sv
// Self-checking bench of the SCL waveform generator
`default_nettype none

module iwg_wave_gen_tb;
	import iwg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int hold; int ex; int hi; int lo; bit hs;} iwg_row_s;

	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_bit = 1'b0;
	logic ack_low = 1'b0;
	iwg_addr_t reg_addr = 8'h00;
	iwg_word_t reg_wdata = 32'h0000_0000;
	iwg_word_t reg_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, scl_w, sda_w;
	int bad_count = 0;
	int checked = 0;
	iwg_row_s rows [4] = '{'{0, 0, 0, 0, 0}, '{5, 2, 3, 4, 0}, '{63, 7, 255, 1, 0}, '{10, 1, 2, 6, 1}};

	always #10 mclk = ~mclk;

	// Next bit is always the opposite, so every data slot shows as an edge
	always @(posedge mclk) tx_bit <= ~sda_out;

	iwg_wave_gen dut (
		.mclk(mclk),
		.srst(srst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.tx_bit(tx_bit),
		.serial_clock_pin_in(scl_w),
		.serial_clock_pin_out(scl_out),
		.serial_clock_pin_oe(scl_oe),
		.serial_data_pin_in(sda_w),
		.serial_data_pin_out(sda_out),
		.serial_data_pin_oe(sda_oe)
	);

	iwg_slave_model slave (
		.scl_oe(scl_oe),
		.sda_oe(sda_oe),
		.ack_low(ack_low),
		.scl_wire(scl_w),
		.sda_wire(sda_w)
	);

	// ----
	// Tasks
	// ----
	task automatic stop_test();
		$display("TB: checks=%0d errors=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input iwg_word_t got, input iwg_word_t want);
		checked++;
		if (got !== want) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk

	task automatic wr(input iwg_addr_t a, input iwg_word_t d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdc(input iwg_addr_t a, input iwg_word_t want);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, want);
	endtask : rdc

	// Bounded wait step: a hang counts as a mismatch
	task automatic tick(inout int k);
		@(posedge mclk);
		#1;
		k++;
		if (k > 40000) begin
			bad_count++;
			stop_test();
		end
	endtask : tick

	// Measures SDA delay after a fall, then the low and the high phase
	task automatic phase(output int hk, output int lk, output int hik);
		logic prev;
		int k;
		k = 0;
		while (scl_out !== 1'b1) tick(k);
		prev = sda_out;
		while (scl_out !== 1'b0) begin
			prev = sda_out;
			tick(k);
		end
		hk = (sda_out !== prev) ? 0 : -1;
		k = 0;
		while (scl_out !== 1'b1) begin
			tick(k);
			if (hk < 0 && sda_out !== prev) hk = k;
		end
		lk = k;
		k = 0;
		while (scl_out !== 1'b0) tick(k);
		hik = k;
	endtask : phase

	// ----
	// Sequence
	// ----
	initial begin
		int hk, lk, hik, k;
		iwg_word_t w;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rdc(OFF_WAVE_CFG, 32'h0000_0000);
		rdc(OFF_WP_STATUS, 32'h0000_0000);
		wr(8'h44, 32'hFFFF_FFFF);
		rdc(8'h44, 32'h0000_0000);
		wr(OFF_WP_STATUS, 32'hFFFF_FFFF);
		rdc(OFF_WP_STATUS, 32'h0000_0000);
		foreach (rows[i]) begin
			w = {2'b00, 6'(rows[i].hold), 5'h00, 3'(rows[i].ex), 8'(rows[i].hi), 8'(rows[i].lo)};
			wr(OFF_CTRL, 32'h0000_0000);
			wr(OFF_WAVE_CFG, w | 32'hC0F8_0000);
			rdc(OFF_WAVE_CFG, w);
			wr(OFF_CTRL, {30'h0, rows[i].hs, 1'b1});
			phase(hk, lk, hik);
			chk(iwg_word_t'(hk), iwg_word_t'(rows[i].hs ? 0 : rows[i].hold + 3));
			chk(iwg_word_t'(lk), iwg_word_t'((rows[i].lo << rows[i].ex) + 3));
			chk(iwg_word_t'(hik), iwg_word_t'((rows[i].hi << rows[i].ex) + 3));
		end
		// Slave operation: lines stay released although a waveform is set
		wr(OFF_CTRL, 32'h0000_0000);
		@(posedge mclk);
		repeat (40) begin
			@(posedge mclk);
			#1;
			chk({28'h0, scl_oe, sda_oe, scl_out, sda_out}, 32'h0000_0003);
		end
		rdc(OFF_STATUS, 32'h0000_0007);
		ack_low <= 1'b1;
		repeat (3) @(posedge mclk);
		rdc(OFF_STATUS, 32'h0000_0005);
		ack_low <= 1'b0;
		// Divider rewrite in mid low phase
		wr(OFF_WAVE_CFG, 32'h0000_0404);
		wr(OFF_CTRL, 32'h0000_0001);
		k = 0;
		while (scl_out !== 1'b0) tick(k);
		wr(OFF_WAVE_CFG, 32'h0000_0A0A);
		k = 0;
		while (scl_out !== 1'b1) tick(k);
		chk(iwg_word_t'(k), 32'h0000_0005);
		k = 0;
		while (scl_out !== 1'b0) tick(k);
		chk(iwg_word_t'(k), 32'h0000_000D);
		// Protected write, sticky flag, read clears
		wr(OFF_WP_MODE, 32'h0000_0001);
		wr(OFF_WAVE_CFG, 32'h0000_FFFF);
		repeat (5) @(posedge mclk);
		rdc(OFF_WAVE_CFG, 32'h0000_0A0A);
		rdc(OFF_WP_STATUS, 32'h0000_1001);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= OFF_WP_STATUS;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk({31'h0, reg_rdata[0]}, 32'h0000_0000);
		wr(OFF_WP_MODE, 32'h0000_0000);
		wr(OFF_WAVE_CFG, 32'h0000_0303);
		rdc(OFF_WAVE_CFG, 32'h0000_0303);
		// Reset in mid run: settings and bus drive must come back idle
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1;
		chk({28'h0, scl_oe, sda_oe, scl_out, sda_out}, 32'h0000_0003);
		rdc(OFF_WAVE_CFG, 32'h0000_0000);
		rdc(OFF_WP_MODE, 32'h0000_0000);
		rdc(OFF_CTRL, 32'h0000_0000);
		stop_test();
	end

endmodule : iwg_wave_gen_tb

`default_nettype wire
